// >>> deo_event_output.sv
`timescale 1ns/1ps
`default_nettype none
module deo_event_output
  import deo_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // version and fitted options
  input  wire logic              dual_sensor,
  input  wire logic              programmable_version,
  input  wire logic              loop_module_present,
  // configuration
  input  wire logic              cfg_load,
  input  wire deo_crit_t         relay_third_sel,
  input  wire deo_tp_mode_t      third_party_mode,
  input  wire logic              latching_enable,
  input  wire logic [5:0]        alarm_delay_s,
  input  wire logic              standard_setting,
  input  wire logic [1:0]        window_sel,
  input  wire logic [9:0]        airflow_delay_s,
  // event sources
  input  wire logic              sensor_alarm_first,
  input  wire logic              sensor_alarm_second,
  input  wire logic              fault_other,
  input  wire logic              third_party_input_a,
  input  wire logic              third_party_input_b,
  input  wire logic              remote_reset_in,
  input  wire logic              initial_reset,
  // airflow measurements
  input  wire logic [FLOW_W-1:0] flow_a,
  input  wire logic [FLOW_W-1:0] flow_b,
  // collector outputs
  output var  logic              collector_output_fault,
  output var  logic              collector_output_alarm_first,
  output var  logic              collector_output_third,
  // relay drives
  output var  logic              relay_fault,
  output var  logic              relay_inactive,
  output var  logic              relay_alarm_first,
  output var  logic              relay_third,
  // status
  output var  logic              device_inactive,
  output var  logic              alarm_first,
  output var  logic              alarm_second,
  output var  logic [1:0]        airflow_fault
);
  typedef struct packed {
    logic [RR_CNT_W-1:0]         rr_cnt;
    logic                        rr_prev;
    logic                        inactive;
    deo_crit_t                   sel;
    deo_tp_mode_t                mode;
    logic [NQ-1:0][Q_CNT_W-1:0]  q_cnt;
    logic [NQ-1:0]               q_act;
    logic [1:0]                  af;
    logic                        oc_fault;
    logic                        oc_alarm;
    logic                        oc_third;
    logic                        rly_fault;
    logic                        rly_inactive;
    logic                        rly_alarm;
    logic                        rly_third;
  } deo_state_t;

  deo_state_t s_reg;
  deo_state_t s_next;

  logic                tick;
  logic [1:0]          af_chan;
  logic [PCT_W-1:0]    win_pct;
  logic [AF_CNT_W-1:0] af_delay_ticks;
  logic [Q_CNT_W-1:0]  q_delay_ticks;

  deo_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk (clk),
    .rst (rst),
    .tick(tick)
  );

  // standard settings override the configured window and delay
  always_comb begin
    win_pct        = standard_setting ? STD_WINDOW_PCT : deo_win_pct(window_sel);
    af_delay_ticks = (standard_setting ? AF_CNT_W'(STD_DELAY_S) : AF_CNT_W'(airflow_delay_s))
                     * AF_TICKS_PER_S;
    q_delay_ticks  = Q_CNT_W'(alarm_delay_s) * Q_TICKS_PER_S;
  end

  // one instance per monitoring area
  deo_airflow_chan u_chan_a (
    .clk        (clk),
    .rst        (rst),
    .tick       (tick),
    .capture    (initial_reset),
    .flow       (flow_a),
    .pct        (win_pct),
    .delay_ticks(af_delay_ticks),
    .fault      (af_chan[0])
  );

  deo_airflow_chan u_chan_b (
    .clk        (clk),
    .rst        (rst),
    .tick       (tick),
    .capture    (initial_reset),
    .flow       (flow_b),
    .pct        (win_pct),
    .delay_ticks(af_delay_ticks),
    .fault      (af_chan[1])
  );

  always_comb begin
    logic              rr_reset;
    logic              clear_ev;
    logic [NQ-1:0]     q_raw;
    logic              any_fault;
    logic              crit_val;
    deo_crit_t         crit_eff;
    rr_reset  = 1'b0;
    clear_ev  = 1'b0;
    q_raw     = '0;
    any_fault = 1'b0;
    crit_val  = 1'b0;
    crit_eff  = CRIT_NONE;
    s_next    = s_reg;

    // stored selector and third-party mode
    if (cfg_load) begin
      s_next.sel  = relay_third_sel;
      s_next.mode = third_party_mode;
    end

    // remote reset: judged by length of the active level
    s_next.rr_prev = remote_reset_in;
    if (remote_reset_in) begin
      if (tick && s_reg.rr_cnt != RR_CNT_MAX) begin
        s_next.rr_cnt = s_reg.rr_cnt + 1'b1;
      end
      // held level deactivates unless a loop module owns that job
      if (s_reg.rr_cnt > RR_HOLD_TICKS && !loop_module_present) begin
        s_next.inactive = 1'b1;
      end
    end else begin
      s_next.rr_cnt = '0;
      if (s_reg.rr_prev && s_reg.rr_cnt >= RR_MIN_TICKS && s_reg.rr_cnt <= RR_MAX_TICKS) begin
        rr_reset = 1'b1;
      end
    end
    // a valid pulse also brings a deactivated device back
    if (rr_reset) begin
      s_next.inactive = 1'b0;
    end
    clear_ev = rr_reset || initial_reset;

    // third-party inputs only act once a mode is configured
    q_raw[Q_ALARM_FIRST]  = sensor_alarm_first
                            || (s_reg.mode == TP_ALARM && third_party_input_a);
    q_raw[Q_ALARM_SECOND] = sensor_alarm_second
                            || (s_reg.mode == TP_ALARM && third_party_input_b);
    q_raw[Q_TP_FAULT]     = s_reg.mode == TP_FAULT
                            && (third_party_input_a || third_party_input_b);

    // shared delay and self-holding for sensor and third-party sources
    for (int i = 0; i < NQ; i++) begin
      if (clear_ev) begin
        s_next.q_cnt[i] = '0;
        s_next.q_act[i] = 1'b0;
      end else if (q_raw[i]) begin
        if (s_reg.q_cnt[i] >= q_delay_ticks) begin
          s_next.q_act[i] = 1'b1;
        end else if (tick) begin
          s_next.q_cnt[i] = s_reg.q_cnt[i] + 1'b1;
        end
      end else begin
        s_next.q_cnt[i] = '0;
        if (!latching_enable) begin
          s_next.q_act[i] = 1'b0;
        end
      end
    end

    // an inactive device raises no alarm outwards
    if (s_next.inactive) begin
      s_next.q_act[Q_ALARM_FIRST]  = 1'b0;
      s_next.q_act[Q_ALARM_SECOND] = 1'b0;
    end

    s_next.af = af_chan;
    any_fault = fault_other || (|af_chan) || s_next.q_act[Q_TP_FAULT] || s_next.inactive;

    // fixed-criterion dual versions ignore the selector
    if (dual_sensor && !programmable_version) begin
      crit_eff = CRIT_ALARM_SECOND;
    end else if (s_reg.sel == CRIT_DEFAULT) begin
      crit_eff = dual_sensor ? CRIT_ALARM_SECOND : CRIT_NONE;
    end else begin
      crit_eff = s_reg.sel;
    end

    unique case (crit_eff)
      CRIT_ALARM_FIRST:  crit_val = s_next.q_act[Q_ALARM_FIRST];
      CRIT_ALARM_SECOND: crit_val = s_next.q_act[Q_ALARM_SECOND];
      CRIT_FAULT:        crit_val = any_fault;
      CRIT_INACTIVE:     crit_val = s_next.inactive;
      CRIT_AIRFLOW:      crit_val = |af_chan;
      default:           crit_val = 1'b0;
    endcase

    s_next.oc_fault     = any_fault;
    s_next.oc_alarm     = s_next.q_act[Q_ALARM_FIRST];
    s_next.rly_third    = crit_val;
    s_next.oc_third     = crit_val;
    // fault relay is fail-safe: energised means healthy
    s_next.rly_fault    = !any_fault;
    s_next.rly_inactive = s_next.inactive;
    s_next.rly_alarm    = s_next.q_act[Q_ALARM_FIRST];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.sel  <= SEL_RESET;
      s_reg.mode <= MODE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign collector_output_fault       = s_reg.oc_fault;
  assign collector_output_alarm_first = s_reg.oc_alarm;
  assign collector_output_third       = s_reg.oc_third;
  assign relay_fault                  = s_reg.rly_fault;
  assign relay_inactive               = s_reg.rly_inactive;
  assign relay_alarm_first            = s_reg.rly_alarm;
  assign relay_third                  = s_reg.rly_third;
  assign device_inactive              = s_reg.inactive;
  assign alarm_first                  = s_reg.q_act[Q_ALARM_FIRST];
  assign alarm_second                 = s_reg.q_act[Q_ALARM_SECOND];
  assign airflow_fault                = s_reg.af;
endmodule
`default_nettype wire

// >>> deo_pkg.sv
// Functional notes
// - fault relay energised unless any fault present
// - relays use fixed or configured criterion
// - collector output one: any fault or inactive
// - collector output two: first sensor alarm
// - output three: second alarm or programmable
// - output three mirrors relay three criterion
// - 0.5 to 10 s reset pulse resets events
// - reset held over 20 s deactivates device
// - no deactivation with loop module installed
// - third-party inputs disabled by default
// - third-party inputs use sensor delay, latching
// - each airflow channel supervised on its own
// - initial reset captures airflow reference values
// - flow outside window around reference faults
// - window width selectable from configured sizes
// - deviation must persist for delay first
// - standard settings: 80/120 percent, 300 s
package deo_pkg;
  localparam int CLK_MHZ         = 100;
  localparam int TICK_MS         = 100;
  localparam int TICK_CYCLES_DEF = TICK_MS * CLK_MHZ * 1000;
  localparam int TICKS_PER_S     = 1000 / TICK_MS;

  localparam int RESET_MIN_MS  = 500;
  localparam int RESET_MAX_MS  = 10000;
  localparam int RESET_HOLD_MS = 20000;
  localparam int FLOW_W        = 10;
  localparam int RR_CNT_W      = 8;
  localparam int Q_CNT_W       = 10;
  localparam int AF_CNT_W      = 14;
  localparam int MUL_W         = 20;
  localparam int PCT_W         = 7;
  localparam int NQ            = 3;

  // least time rounds up, longest rounds down
  localparam logic [RR_CNT_W-1:0] RR_MIN_TICKS  = RR_CNT_W'((RESET_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [RR_CNT_W-1:0] RR_MAX_TICKS  = RR_CNT_W'(RESET_MAX_MS / TICK_MS);
  localparam logic [RR_CNT_W-1:0] RR_HOLD_TICKS = RR_CNT_W'(RESET_HOLD_MS / TICK_MS);
  localparam logic [RR_CNT_W-1:0] RR_CNT_MAX    = {RR_CNT_W{1'b1}};
  localparam logic [Q_CNT_W-1:0]  Q_TICKS_PER_S = Q_CNT_W'(TICKS_PER_S);
  localparam logic [AF_CNT_W-1:0] AF_TICKS_PER_S = AF_CNT_W'(TICKS_PER_S);
  localparam logic [AF_CNT_W-1:0] AF_CNT_MAX    = {AF_CNT_W{1'b1}};

  localparam logic [MUL_W-1:0] PCT_FULL        = 20'h00064;
  localparam logic [PCT_W-1:0] STD_WINDOW_PCT  = 7'h14;
  localparam logic [9:0]       STD_DELAY_S     = 10'h12c;
  localparam logic [PCT_W-1:0] WIN_PCT_0       = 7'h0a;
  localparam logic [PCT_W-1:0] WIN_PCT_1       = 7'h14;
  localparam logic [PCT_W-1:0] WIN_PCT_2       = 7'h1e;
  localparam logic [PCT_W-1:0] WIN_PCT_3       = 7'h32;

  localparam int Q_ALARM_FIRST  = 0;
  localparam int Q_ALARM_SECOND = 1;
  localparam int Q_TP_FAULT     = 2;

  typedef enum logic [2:0] {
    CRIT_DEFAULT, CRIT_ALARM_FIRST, CRIT_ALARM_SECOND, CRIT_FAULT,
    CRIT_INACTIVE, CRIT_AIRFLOW, CRIT_NONE
  } deo_crit_t;

  typedef enum logic [1:0] {TP_OFF, TP_ALARM, TP_FAULT} deo_tp_mode_t;

  localparam deo_crit_t    SEL_RESET  = CRIT_DEFAULT;
  localparam deo_tp_mode_t MODE_RESET = TP_OFF;

  function automatic logic [PCT_W-1:0] deo_win_pct(input logic [1:0] sel);
    logic [PCT_W-1:0] p;
    p = WIN_PCT_0;
    unique case (sel)
      2'h0: p = WIN_PCT_0;
      2'h1: p = WIN_PCT_1;
      2'h2: p = WIN_PCT_2;
      2'h3: p = WIN_PCT_3;
    endcase
    return p;
  endfunction

  function automatic logic deo_out_of_window(input logic [FLOW_W-1:0] act,
                                             input logic [FLOW_W-1:0] ref_v,
                                             input logic [PCT_W-1:0] pct);
    logic [MUL_W-1:0] a;
    logic [MUL_W-1:0] lo;
    logic [MUL_W-1:0] hi;
    a  = MUL_W'(act) * PCT_FULL;
    lo = MUL_W'(ref_v) * (PCT_FULL - MUL_W'(pct));
    hi = MUL_W'(ref_v) * (PCT_FULL + MUL_W'(pct));
    return (a < lo) || (a > hi);
  endfunction
endpackage

// >>> deo_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module deo_tick_div
  import deo_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // slow enable
  output var  logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } deo_div_t;

  deo_div_t s_reg;
  deo_div_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= 32'(TICK_CYCLES - 1)) begin
      s_next.cnt  = 32'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule
`default_nettype wire

// >>> deo_airflow_chan.sv
`timescale 1ns/1ps
`default_nettype none
module deo_airflow_chan
  import deo_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                tick,
  // measurement and settings
  input  wire logic                capture,
  input  wire logic [FLOW_W-1:0]   flow,
  input  wire logic [PCT_W-1:0]    pct,
  input  wire logic [AF_CNT_W-1:0] delay_ticks,
  // result
  output var  logic                fault
);
  typedef struct packed {
    logic [FLOW_W-1:0]   ref_v;
    logic                ref_ok;
    logic [AF_CNT_W-1:0] cnt;
    logic                fault;
  } deo_chan_t;

  deo_chan_t s_reg;
  deo_chan_t s_next;

  always_comb begin
    s_next = s_reg;
    if (capture) begin
      // reference becomes the 100 percent point
      s_next.ref_v  = flow;
      s_next.ref_ok = 1'b1;
      s_next.cnt    = '0;
      s_next.fault  = 1'b0;
    end else if (s_reg.ref_ok && deo_out_of_window(flow, s_reg.ref_v, pct)) begin
      // fault only once the delay has fully run out
      if (tick) begin
        if (s_reg.cnt >= delay_ticks) begin
          s_next.fault = 1'b1;
        end else if (s_reg.cnt != AF_CNT_MAX) begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end
    end else begin
      // a short disturbance restarts the wait
      s_next.cnt   = '0;
      s_next.fault = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fault = s_reg.fault;
endmodule
`default_nettype wire

// >>> deo_event_output_properties.sv
`timescale 1ns/1ps
`default_nettype none
module deo_event_output_props #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // watched inputs
  input wire logic       dual_sensor,
  input wire logic       programmable_version,
  input wire logic       loop_module_present,
  input wire logic [5:0] alarm_delay_s,
  input wire logic       sensor_alarm_first,
  input wire logic       remote_reset_in,
  input wire logic       initial_reset,
  // watched outputs
  input wire logic       collector_output_fault,
  input wire logic       collector_output_alarm_first,
  input wire logic       collector_output_third,
  input wire logic       relay_fault,
  input wire logic       relay_third,
  input wire logic       device_inactive,
  input wire logic       alarm_first,
  input wire logic       alarm_second,
  input wire logic [1:0] airflow_fault
);
  int unsigned hold_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= remote_reset_in ? hold_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // both flops still hold reset zeros at the first edge after release
  a_fault_relay_mirror: assert property (!$past(rst) |-> relay_fault != collector_output_fault)
    else $error("fault relay and fault output agree");
  a_inactive_faults: assert property (device_inactive && $past(device_inactive) |-> collector_output_fault)
    else $error("inactive without fault output");
  a_alarm_out_first: assert property (collector_output_alarm_first == alarm_first)
    else $error("output two differs from first alarm");
  a_third_same: assert property (collector_output_third == relay_third)
    else $error("output three differs from relay three");
  a_dual_second: assert property (dual_sensor && !programmable_version && $rose(alarm_second)
    |-> ##[0:1] collector_output_third)
    else $error("output three missed second alarm");
  a_loop_blocks: assert property (loop_module_present && $past(loop_module_present)
    |-> !$rose(device_inactive))
    else $error("deactivated with loop module");
  a_hold_time: assert property ($rose(device_inactive) |-> hold_cnt >= 200 * TICK_CYCLES)
    else $error("deactivated before hold time");
  a_airflow_fault: assert property (|airflow_fault |-> collector_output_fault)
    else $error("airflow fault not reported");
  a_zero_delay: assert property (alarm_delay_s == 6'h0 && sensor_alarm_first && !device_inactive
    && !remote_reset_in && !$past(remote_reset_in) && !initial_reset |=> alarm_first)
    else $error("undelayed alarm late");
  c_inactive: cover property ($rose(device_inactive));
  c_airflow: cover property ($rose(airflow_fault[0]));
  c_alarm_clear: cover property ($fell(alarm_first));
endmodule
bind deo_event_output deo_event_output_props #(.TICK_CYCLES(TICK_CYCLES)) deo_event_output_props_inst (
  .clk(clk), .rst(rst), .dual_sensor(dual_sensor), .programmable_version(programmable_version),
  .loop_module_present(loop_module_present), .alarm_delay_s(alarm_delay_s),
  .sensor_alarm_first(sensor_alarm_first), .remote_reset_in(remote_reset_in), .initial_reset(initial_reset),
  .collector_output_fault(collector_output_fault), .collector_output_alarm_first(collector_output_alarm_first),
  .collector_output_third(collector_output_third), .relay_fault(relay_fault), .relay_third(relay_third),
  .device_inactive(device_inactive), .alarm_first(alarm_first), .alarm_second(alarm_second),
  .airflow_fault(airflow_fault));
`default_nettype wire

// >>> deo_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module deo_panel_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // press request
  input  wire logic        press,
  input  wire logic [15:0] press_len,
  // contact towards the device
  output var  logic        remote_reset_in,
  output var  logic        busy
);
  logic [15:0] left_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg <= 16'h0;
    end else if (press) begin
      left_reg <= press_len;
    end else if (left_reg != 16'h0) begin
      left_reg <= left_reg - 16'h1;
    end
  end
  // contact closed for exactly press_len cycles
  always_comb begin
    remote_reset_in = (left_reg != 16'h0);
    busy = remote_reset_in;
  end
endmodule
`default_nettype wire

// >>> deo_event_output_test.sv
`timescale 1ns/1ps
`default_nettype none
module deo_event_output_test;
  import deo_pkg::*;
  logic clk, rst, dual_sensor, programmable_version, loop_module_present, cfg_load, latching_enable;
  logic standard_setting, sensor_alarm_first, sensor_alarm_second, fault_other, initial_reset;
  logic third_party_input_a, third_party_input_b, remote_reset_in, press, busy;
  logic collector_output_fault, collector_output_alarm_first, collector_output_third, relay_fault;
  logic relay_inactive, relay_alarm_first, relay_third, device_inactive, alarm_first, alarm_second;
  logic [1:0] window_sel, airflow_fault;
  logic [5:0] alarm_delay_s;
  logic [9:0] airflow_delay_s, flow_a, flow_b;
  logic [15:0] press_len;
  deo_crit_t relay_third_sel;
  deo_tp_mode_t third_party_mode;
  int err_count = 0;
  int n_checks = 0;

  deo_event_output #(.TICK_CYCLES(10)) deo_event_output_inst (.clk(clk), .rst(rst),
    .dual_sensor(dual_sensor), .programmable_version(programmable_version),
    .loop_module_present(loop_module_present), .cfg_load(cfg_load), .relay_third_sel(relay_third_sel),
    .third_party_mode(third_party_mode), .latching_enable(latching_enable), .alarm_delay_s(alarm_delay_s),
    .standard_setting(standard_setting), .window_sel(window_sel), .airflow_delay_s(airflow_delay_s),
    .sensor_alarm_first(sensor_alarm_first), .sensor_alarm_second(sensor_alarm_second),
    .fault_other(fault_other), .third_party_input_a(third_party_input_a),
    .third_party_input_b(third_party_input_b), .remote_reset_in(remote_reset_in),
    .initial_reset(initial_reset), .flow_a(flow_a), .flow_b(flow_b),
    .collector_output_fault(collector_output_fault), .collector_output_alarm_first(collector_output_alarm_first),
    .collector_output_third(collector_output_third), .relay_fault(relay_fault), .relay_inactive(relay_inactive),
    .relay_alarm_first(relay_alarm_first), .relay_third(relay_third), .device_inactive(device_inactive),
    .alarm_first(alarm_first), .alarm_second(alarm_second), .airflow_fault(airflow_fault));
  deo_panel_model deo_panel_model_inst (.clk(clk), .rst(rst), .press(press), .press_len(press_len),
    .remote_reset_in(remote_reset_in), .busy(busy));

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load_cfg(input deo_crit_t sel, input deo_tp_mode_t m);
    relay_third_sel = sel;
    third_party_mode = m;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask
  task automatic press_reset(input logic [15:0] len);
    int i;
    press_len = len;
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    for (i = 0; i < 5000 && busy; i++) cyc(1);
    if (busy !== 1'b0) begin
      err_count++;
      finish_test();
    end
    cyc(3);
  endtask

  task automatic t_third_party();
    check(relay_fault, 1'b1, "relay idle");
    check(collector_output_fault, 1'b0, "fault out idle");
    third_party_input_a = 1'b1;
    third_party_input_b = 1'b1;
    cyc(30);
    check(alarm_first, 1'b0, "inputs off");
    check(collector_output_fault, 1'b0, "inputs off fault");
    load_cfg(CRIT_DEFAULT, TP_ALARM);
    cyc(3);
    check(relay_alarm_first, 1'b1, "input a alarm");
    check(alarm_second, 1'b1, "input b alarm");
    check(collector_output_alarm_first, 1'b1, "alarm out");
    load_cfg(CRIT_DEFAULT, TP_FAULT);
    cyc(3);
    check(alarm_first, 1'b0, "unlatched drop");
    check(relay_fault, 1'b0, "input fault");
    third_party_input_a = 1'b0;
    third_party_input_b = 1'b0;
    cyc(3);
    check(relay_fault, 1'b1, "fault gone");
    load_cfg(CRIT_DEFAULT, TP_OFF);
  endtask
  task automatic t_latch();
    alarm_delay_s = 6'h1;
    latching_enable = 1'b1;
    sensor_alarm_first = 1'b1;
    cyc(80);
    check(alarm_first, 1'b0, "before delay");
    cyc(40);
    check(alarm_first, 1'b1, "after delay");
    sensor_alarm_first = 1'b0;
    cyc(5);
    press_reset(16'h14);
    check(alarm_first, 1'b1, "short pulse");
    press_reset(16'h12c);
    check(collector_output_alarm_first, 1'b0, "valid pulse");
    latching_enable = 1'b0;
    alarm_delay_s = 6'h0;
  endtask
  task automatic t_hold();
    loop_module_present = 1'b1;
    press_reset(16'h866);
    check(device_inactive, 1'b0, "loop fitted");
    loop_module_present = 1'b0;
    press_reset(16'h866);
    check(device_inactive, 1'b1, "held");
    check(collector_output_fault, 1'b1, "inactive fault out");
    check(relay_inactive, 1'b1, "inactive relay");
    sensor_alarm_first = 1'b1;
    cyc(3);
    check(alarm_first, 1'b0, "inactive quiet");
    sensor_alarm_first = 1'b0;
    programmable_version = 1'b1;
    load_cfg(CRIT_INACTIVE, TP_OFF);
    cyc(2);
    check(relay_third, 1'b1, "selected inactive");
    press_reset(16'h12c);
    check(device_inactive, 1'b0, "reactivated");
    check(relay_inactive, 1'b0, "relay released");
    check(collector_output_third, 1'b0, "selected active");
    load_cfg(CRIT_DEFAULT, TP_OFF);
    programmable_version = 1'b0;
  endtask
  task automatic t_third_out();
    dual_sensor = 1'b1;
    sensor_alarm_second = 1'b1;
    cyc(3);
    check(collector_output_third, 1'b1, "dual output three");
    check(relay_third, 1'b1, "dual relay3");
    sensor_alarm_second = 1'b0;
    dual_sensor = 1'b0;
    programmable_version = 1'b1;
    load_cfg(CRIT_FAULT, TP_OFF);
    fault_other = 1'b1;
    cyc(3);
    check(collector_output_third, 1'b1, "selected fault");
    fault_other = 1'b0;
    load_cfg(CRIT_ALARM_FIRST, TP_OFF);
    sensor_alarm_first = 1'b1;
    cyc(1);
    check(alarm_first, 1'b1, "undelayed alarm");
    cyc(2);
    check(collector_output_third, 1'b1, "selected alarm one");
    sensor_alarm_first = 1'b0;
    load_cfg(CRIT_DEFAULT, TP_OFF);
    sensor_alarm_second = 1'b1;
    cyc(3);
    check(relay_third, 1'b0, "single default");
    sensor_alarm_second = 1'b0;
    programmable_version = 1'b0;
  endtask
  task automatic t_airflow();
    check(airflow_fault[0], 1'b0, "no reference");
    programmable_version = 1'b1;
    load_cfg(CRIT_AIRFLOW, TP_OFF);
    initial_reset = 1'b1;
    cyc(1);
    initial_reset = 1'b0;
    flow_a = 10'h59;
    cyc(180);
    check(airflow_fault[0], 1'b0, "within delay");
    check(relay_third, 1'b0, "airflow quiet");
    cyc(60);
    check(airflow_fault[0], 1'b1, "below window");
    check(airflow_fault[1], 1'b0, "other channel");
    check(collector_output_third, 1'b1, "selected airflow");
    check(relay_fault, 1'b0, "airflow relay");
    flow_a = 10'h64;
    window_sel = 2'h3;
    cyc(3);
    check(airflow_fault[0], 1'b0, "back inside");
    flow_a = 10'h3c;
    cyc(300);
    check(airflow_fault[0], 1'b0, "wide window");
    standard_setting = 1'b1;
    flow_a = 10'h4f;
    cyc(29950);
    check(airflow_fault[0], 1'b0, "standard delay");
    cyc(110);
    check(airflow_fault[0], 1'b1, "standard fault");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, dual_sensor, programmable_version, loop_module_present, cfg_load, latching_enable} = 6'h20;
    {standard_setting, sensor_alarm_first, sensor_alarm_second, fault_other, initial_reset} = 5'h0;
    {third_party_input_a, third_party_input_b, press, window_sel} = 5'h0;
    alarm_delay_s = 6'h0;
    airflow_delay_s = 10'h2;
    flow_a = 10'h64;
    flow_b = 10'h64;
    press_len = 16'h0;
    relay_third_sel = CRIT_DEFAULT;
    third_party_mode = TP_OFF;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    t_third_party();
    t_latch();
    t_hold();
    t_third_out();
    t_airflow();
    finish_test();
  end
endmodule
`default_nettype wire
